// ===== verilog/aps_regs.vh
// Constants for the parallel sample output block
`ifndef APS_REGS_VH
`define APS_REGS_VH
`define APS_DATA_W      14
`define APS_WORD_W      15
`define APS_LATENCY     3
`define APS_LAT_W       2
`define APS_FIFO_DEPTH  4
`define APS_FIFO_AW     2
`define APS_FULL_POS    14'h1fff
`define APS_FULL_NEG    14'h2000
`define APS_ZERO_DATA   14'h0000
`endif

// ===== verilog/aps_fifo.v
// Small synchronous FIFO for sample words
`timescale 1ns/1ps
module aps_fifo
#(
    parameter WIDTH = 15,
    parameter DEPTH = 4,
    parameter AW    = 2
)
(
    input  wire             clk,       // System clock
    input  wire             sys_rst,   // Synchronous reset
    input  wire             clk_en,    // Freeze when low
    input  wire [WIDTH-1:0] in_data,   // Write data
    input  wire             in_valid,  // Write request
    output wire             in_ready,  // Room available
    output reg  [WIDTH-1:0] out_data,  // Registered read data
    output reg              out_valid, // Read data valid
    input  wire             out_ready  // Drain side accepts
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // Storage
    reg [AW-1:0]    wp_ff;              // Write pointer
    reg [AW-1:0]    rp_ff;              // Read pointer
    reg [AW:0]      cnt_ff;             // Fill count
    wire            do_wr;              // Write accepted
    wire            do_rd;              // Move word to output
    wire            ld_ok;              // Output slot free

    assign in_ready = (cnt_ff != DEPTH[AW:0]);
    assign do_wr    = in_valid && in_ready;
    assign ld_ok    = !out_valid || out_ready;
    assign do_rd    = (cnt_ff != {(AW+1){1'b0}}) && ld_ok;

    //--------------------------------------------
    // Storage, pointers and output register
    //--------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            wp_ff     <= {AW{1'b0}};
            rp_ff     <= {AW{1'b0}};
            cnt_ff    <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end
        else if (clk_en)
        begin
            if (do_wr)
            begin
                mem_ff[wp_ff] <= in_data;
                wp_ff         <= wp_ff + 1'b1;
            end
            if (do_rd)
            begin
                out_data  <= mem_ff[rp_ff];
                rp_ff     <= rp_ff + 1'b1;
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
            cnt_ff <= cnt_ff + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
        end
    end
endmodule

// ===== verilog/aps_core.v
// Converter digital output stage: latency pipe, FIFO, output word and strobe
`timescale 1ns/1ps
`include "aps_regs.vh"

// Timing overview, in detected rises of the sample clock:
//   rise k      code of edge k is clamped into stage 0
//   rise k+1    word moves to stage 1
//   rise k+2    word moves to stage 2
//   +1 clk      word is pushed into the FIFO
//   +2 clk      FIFO head register takes the word
//   rise k+3    word and flag reach the pins, strobe drops
//   next fall   strobe rises, the receiver takes the sample
// A rise is seen three clk after the pin moves, so each phase of
// the sample clock must last at least three clk for the push and
// the head load to finish between rises. A short freeze of clk_en
// only stretches this timing.
module aps_core
(
    input  wire                    clk,                // System clock, 25 MHz
    input  wire                    sys_rst,            // Synchronous reset, high
    input  wire                    clk_en,             // Freeze all state when low
    input  wire                    sample_clock_input, // Sample clock pin
    input  wire signed [15:0]      analog_code,        // Quantised analog level, async
    output reg  [`APS_DATA_W-1:0]  out_word,           // output_msb..output_lsb
    output reg                     overrange_flag,     // Input beyond full scale
    output reg                     sample_ready_strobe,// Data-ready strobe
    output reg                     fifo_overflow       // Sticky: sample lost on full FIFO
);
    //--------------------------------------------
    // Input synchronisers
    //--------------------------------------------
    reg         sclk_s1_ff;   // First stage, read only by second
    reg         sclk_s2_ff;   // Second stage
    reg         sclk_d_ff;    // Previous synchronised level
    reg  [15:0] ain_s1_ff;    // Analog code first stage
    reg  [15:0] ain_s2_ff;    // Analog code second stage
    wire        rise;         // Sample clock rising edge
    wire        fall;         // Sample clock falling edge

    // Two flops per input, one more for the edge detector
    // The analog word crosses whole; it is held steady around each rise
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_d_ff  <= 1'b0;
            ain_s1_ff  <= 16'h0000;
            ain_s2_ff  <= 16'h0000;
        end
        else if (clk_en)
        begin
            sclk_s1_ff <= sample_clock_input;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_d_ff  <= sclk_s2_ff;
            ain_s1_ff  <= analog_code;
            ain_s2_ff  <= ain_s1_ff;
        end
    end

    // Detector flops reset low, the idle pin level, so no false edge
    assign rise = sclk_s2_ff && !sclk_d_ff;
    assign fall = !sclk_s2_ff && sclk_d_ff;

    //--------------------------------------------
    // Quantiser: clamp and flag overrange
    //--------------------------------------------
    // Clamp codes past either full scale and raise the flag
    function [`APS_WORD_W-1:0] quantise;
        input signed [15:0] v;
        begin
            if (v > $signed({2'b00, `APS_FULL_POS}))
                quantise = {1'b1, `APS_FULL_POS};
            else if (v < $signed({2'b11, `APS_FULL_NEG}))
                quantise = {1'b1, `APS_FULL_NEG};
            // In range: the low bits pass as two's complement
            else
                quantise = {1'b0, v[`APS_DATA_W-1:0]};
        end
    endfunction

    //--------------------------------------------
    // Latency pipe, advances on each rise
    //--------------------------------------------
    reg  [`APS_WORD_W-1:0] pipe_ff [0:`APS_LATENCY-1]; // Stage words
    reg  [`APS_LAT_W:0]    fill_ff;                    // Stages filled

    // Stages 1 and up shift on each rise
    genvar gi;
    generate
        for (gi = 1; gi < `APS_LATENCY; gi = gi + 1)
        begin : g_pipe
            always @(posedge clk)
            begin
                if (sys_rst)
                    pipe_ff[gi] <= {`APS_WORD_W{1'b0}};
                else if (clk_en && rise)
                    pipe_ff[gi] <= pipe_ff[gi-1];
            end
        end
    endgenerate

    // Capture the input on every rise
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            pipe_ff[0] <= {`APS_WORD_W{1'b0}};
            fill_ff    <= {(`APS_LAT_W+1){1'b0}};
        end
        else if (clk_en && rise)
        begin
            pipe_ff[0] <= quantise(ain_s2_ff);
            // Fill count stops once every stage holds a real word
            if (fill_ff != `APS_LATENCY)
                fill_ff <= fill_ff + 1'b1;
        end
    end

    //--------------------------------------------
    // Push timing
    //--------------------------------------------
    // The last stage holds the word of edge k only after the rise that
    // moved it there, so the push waits one clk behind that rise. A push
    // on the rise itself would take the older word and add a whole
    // sample period of latency at the pins.
    reg                    rise_d_ff;   // Rise pulse, one clk late

    // Delayed rise, frozen with the rest of the state
    always @(posedge clk)
    begin
        if (sys_rst)
            rise_d_ff <= 1'b0;                                    // No push pending
        else if (clk_en)
            rise_d_ff <= rise;
    end

    //--------------------------------------------
    // FIFO between pipe and output pins
    //--------------------------------------------
    wire                   f_in_ready;  // FIFO has room
    wire [`APS_WORD_W-1:0] f_out_data;  // Head word
    wire                   f_out_valid; // Head valid
    wire                   push;        // Pipe output pushed
    wire                   pop;         // Output pins take head

    // Push the word of edge k one clk after rise k+2
    assign push = rise_d_ff && (fill_ff == `APS_LATENCY);
    assign pop  = rise;

    // Holds finished words until the pins take them on a rise
    aps_fifo
    #(
        .WIDTH (`APS_WORD_W),
        .DEPTH (`APS_FIFO_DEPTH),
        .AW    (`APS_FIFO_AW)
    )
    u_fifo
    (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_data   (pipe_ff[`APS_LATENCY-1]),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .out_data  (f_out_data),
        .out_valid (f_out_valid),
        .out_ready (pop)
    );

    //--------------------------------------------
    // Output word, flag and strobe
    //--------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_word            <= `APS_ZERO_DATA;
            overrange_flag      <= 1'b0;
            sample_ready_strobe <= 1'b0;
        end
        else if (clk_en)
        begin
            // Update only on clock rise, strobe drops
            if (rise)
            begin
                sample_ready_strobe <= 1'b0;
                // Head word to the pins, flag from its top bit
                if (f_out_valid)
                begin
                    out_word       <= f_out_data[`APS_DATA_W-1:0];
                    overrange_flag <= f_out_data[`APS_DATA_W];
                end
            end
            // Strobe rises on the detected fall, inverting the clock
            else if (fall)
                sample_ready_strobe <= 1'b1;
        end
    end

    //--------------------------------------------
    // Status: lost sample detection
    //--------------------------------------------
    // One push per sample period and one pop on every rise keep the
    // FIFO nearly empty, so this sticky flag only records a word that
    // was refused anyway. Only reset clears it.
    always @(posedge clk)
    begin
        if (sys_rst)
            fifo_overflow <= 1'b0;                                // Nothing lost yet
        else if (clk_en && push && !f_in_ready)
            fifo_overflow <= 1'b1;                                // Lost sample
    end
endmodule

// ===== verification/aps_core_props.sv
// Checker for word, flag and strobe timing at the output pins
`timescale 1ns/1ps
module aps_core_props
(
    input wire        clk,                 // System clock
    input wire        sys_rst,             // Synchronous reset
    input wire        sample_clock_input,  // Sample clock pin
    input wire [13:0] out_word,            // Output word
    input wire        overrange_flag,      // Overrange flag
    input wire        sample_ready_strobe, // Data-ready strobe
    input wire        fifo_overflow        // Lost sample status
);
    // --------------------------------
    // Properties
    // --------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_strobe_in_high; $fell(sample_ready_strobe) |-> sample_clock_input; endproperty
    property p_rise_to_low; $rose(sample_clock_input) |-> ##[2:4] !sample_ready_strobe; endproperty
    property p_fall_to_high; $fell(sample_clock_input) |-> ##[2:4] sample_ready_strobe; endproperty
    property p_low_holds; $fell(sample_ready_strobe) |-> !sample_ready_strobe [*3]; endproperty
    property p_word_on_fall; $changed({overrange_flag, out_word}) |-> $fell(sample_ready_strobe); endproperty
    property p_word_stands; $fell(sample_ready_strobe) |=> $stable({overrange_flag, out_word}) [*6]; endproperty
    property p_flag_clamp; overrange_flag |-> (out_word == 14'h1fff || out_word == 14'h2000); endproperty
    a_strobe_in_high: assert property (p_strobe_in_high) else $error("strobe fell with pin low");
    a_rise_to_low: assert property (p_rise_to_low) else $error("strobe not low after rise");
    a_fall_to_high: assert property (p_fall_to_high) else $error("strobe not high after fall");
    a_low_holds: assert property (p_low_holds) else $error("strobe low pulse too short");
    a_word_on_fall: assert property (p_word_on_fall) else $error("word moved off strobe fall");
    a_word_stands: assert property (p_word_stands) else $error("word not held");
    a_flag_clamp: assert property (p_flag_clamp) else $error("flag without full scale word");
    property p_no_loss; !fifo_overflow; endproperty
    a_no_loss: assert property (p_no_loss) else $error("sample lost in output FIFO");
    // Main scenarios reached
    c_strobe: cover property ($rose(sample_ready_strobe));
    c_pos: cover property (overrange_flag && out_word == 14'h1fff);
    c_neg: cover property (overrange_flag && out_word == 14'h2000);
endmodule
bind aps_core aps_core_props aps_core_props_inst (.clk(clk), .sys_rst(sys_rst),
    .sample_clock_input(sample_clock_input), .out_word(out_word),
    .overrange_flag(overrange_flag), .sample_ready_strobe(sample_ready_strobe),
    .fifo_overflow(fifo_overflow));

// ===== verification/aps_rx_model.sv
// Receiver model: takes one sample per strobe rise
`timescale 1ns/1ps
module aps_rx_model
(
    input wire        sample_ready_strobe, // Data-ready strobe
    input wire [13:0] out_word,            // Output word
    input wire        overrange_flag,      // Overrange flag
    output reg [14:0] rx_data,             // Captured flag and word
    output integer    rx_count             // Samples taken
);
    initial rx_count = 0;
    // Word and flag taken together as one sample
    always @(posedge sample_ready_strobe)
    begin
        rx_data <= {overrange_flag, out_word};
        rx_count <= rx_count + 1;
    end
endmodule

// ===== verification/tb.sv
// Testbench: boundary and random samples through the output stage
`timescale 1ns/1ps
module tb;
    reg               clk, sys_rst, clk_en, sample_clock_input; // Driven inputs
    reg signed [15:0] analog_code;                              // Analog stand-in
    wire [13:0]       out_word;                                 // Output word
    wire              overrange_flag, sample_ready_strobe, fifo_overflow; // Flag, strobe, status
    wire [14:0]       rx_data;                                  // Receiver capture
    integer           rx_count, errors, checks, cyc, seed, i, v; // Counters
    reg [14:0]        exp_q[$];                                 // Expected samples
    reg [14:0]        e;                                        // Popped expectation
    int               vals[8] = '{8191, 8192, -8192, -8193, 0, -1, 32767, -32768};
    aps_core aps_core_inst (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .sample_clock_input(sample_clock_input), .analog_code(analog_code), .out_word(out_word),
        .overrange_flag(overrange_flag), .sample_ready_strobe(sample_ready_strobe), .fifo_overflow(fifo_overflow));
    aps_rx_model aps_rx_model_inst (.sample_ready_strobe(sample_ready_strobe), .out_word(out_word),
        .overrange_flag(overrange_flag), .rx_data(rx_data), .rx_count(rx_count));
    initial
    begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 1000)
        begin
            errors = errors + 1;
            final_report;
        end
    end
    // Clamp and code a level
    function [14:0] model(input integer x);
        if (x > 8191) model = {1'b1, 14'h1fff};
        else if (x < -8192) model = {1'b1, 14'h2000};
        else model = {1'b0, x[13:0]};
    endfunction
    // One 320 ns sample clock period, level set in low phase
    task sample(input integer val);
        analog_code = val[15:0];
        repeat (4) @(negedge clk);
        sample_clock_input = 1;
        exp_q.push_back(model(val));
        repeat (4) @(negedge clk);
        sample_clock_input = 0;
    endtask
    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Word at rise k+3 belongs to edge k
    always @(rx_count)
    begin
        if (rx_count > 3)
        begin
            e = exp_q.pop_front();
            checks = checks + 1;
            if (rx_data !== e)
            begin
                errors = errors + 1;
                $display("ERROR rx_data expected %h seen %h", e, rx_data);
            end
        end
    end
    initial
    begin
        seed = 32'h337781ca;
        {errors, checks, cyc} = 0;
        {clk_en, sys_rst, sample_clock_input} = 3'b110;
        analog_code = 0;
        repeat (8) @(negedge clk);
        sys_rst = 0;
        for (i = 0; i < 8; i++) sample(vals[i]);
        $display("boundary test done");
        for (i = 0; i < 24; i++)
        begin
            v = $random(seed) % 12000;
            sample(v);
        end
        $display("random test done");
        // Flush, with clk_en low for one clk early in each low phase
        for (i = 0; i < 5; i++)
        begin
            fork
                sample(0);
                begin
                    @(negedge clk);
                    clk_en = 0;
                    @(negedge clk);
                    clk_en = 1;
                end
            join
        end
        $display("freeze test done");
        repeat (8) @(negedge clk);
        // 37 samples, the last three still in the pipe
        if (checks != 34)
        begin
            errors = errors + 1;
            $display("ERROR checks expected 34 seen %0d", checks);
        end
        checks = checks + 1;
        if (fifo_overflow !== 1'b0)
        begin
            errors = errors + 1;
            $display("ERROR fifo_overflow expected 0 seen %b", fifo_overflow);
        end
        final_report;
    end
endmodule
